// *** pkg/mctf_pkg.sv ***
// Constants, types and helper functions of the multicarrier transmit framer
package mctf_pkg;

    // ==========================================================
    // Octet values and field arithmetic
    localparam logic [7:0]  GF_POLY_LOW  = 8'h1d;
    localparam logic [7:0]  GF_ONE       = 8'h01;
    localparam logic [7:0]  GF_ALPHA     = 8'h02;
    localparam logic [7:0]  STUFF_DUMMY  = 8'h3a;
    localparam logic [7:0]  FILL_DUMMY   = 8'hd3;
    localparam logic [7:0]  STUFF_PERIOD = 8'h8a;
    localparam logic [8:0]  MAX_CODEWORD = 9'h0ff;
    localparam logic [4:0]  MAX_CHECK    = 5'h10;
    localparam int          CHECK_SLOTS  = 16;

    // ==========================================================
    // Scrambler
    localparam int          SCR_LEN      = 23;
    localparam int          SCR_TAP_A    = 17;
    localparam int          SCR_TAP_B    = 22;
    localparam logic [22:0] SCR_SEED     = 23'h000001;

    // ==========================================================
    // Delay rings
    localparam int          RING_AW      = 12;

    typedef enum logic [1:0] {ST_IDLE, ST_GEN, ST_RUN} mctf_state_t;

    // ==========================================================
    // Helpers
    function automatic logic [7:0] bit_rev(input logic [7:0] a);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = a[7-i];
        end
        return r;
    endfunction

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] r;
        logic [7:0] x;
        r = '0;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                r = r ^ x;
            end
            x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY_LOW : 8'h00);
        end
        return r;
    endfunction

    // Bit 0 goes first; returns {next state, octet}; desc picks the descrambling form
    function automatic logic [30:0] scramble(input logic [7:0] m, input logic [22:0] s, input logic desc);
        logic [22:0] st;
        logic [7:0]  y;
        st = s;
        y  = '0;
        for (int b = 0; b < 8; b++) begin
            y[b] = m[b] ^ st[SCR_TAP_A] ^ st[SCR_TAP_B];
            st   = {st[SCR_LEN-2:0], desc ? m[b] : y[b]};
        end
        return {st, y};
    endfunction

endpackage

// *** rtl/mctf_delay_ring.sv ***
// Octet ring that returns each octet a programmable number of steps later
`timescale 1ns/100ps
module mctf_delay_ring (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              nrst,
    // Octet stream
    input  wire logic                              step,
    input  wire logic [7:0]                        din,
    input  wire logic [mctf_pkg::RING_AW-1:0]      delay,
    output logic      [7:0]                        dout
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Storage
    logic [7:0]                   mem [2**mctf_pkg::RING_AW];
    logic [mctf_pkg::RING_AW-1:0] wptr_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wptr_q <= '0;
        end else if (step) begin
            wptr_q <= wptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (step) begin
            mem[wptr_q] <= din;
        end
    end

    // Zero delay bypasses the memory, so the octet written now leaves now
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dout <= '0;
        end else if (step) begin
            dout <= (delay == '0) ? din : mem[wptr_q - delay]; // R12 R15 R17
        end
    end

    // ==========================================================
    // Checks
    a_ring_bypass: assert property (step && delay == '0 |=> dout == $past(din)) // R15
        else $error("zero delay did not pass the octet straight through");

endmodule

// *** rtl/mctf_framer.sv ***
// Multicarrier transmit framer: adaptation, scrambling, coding, interleaving
// Operation
// [R1] Each line octet is sent most significant bit first.
// [R2] Serial processing runs LSB first, payload MSB taken as LSB.
// [R3] Scrambler output is input plus outputs 18 and 23 bits earlier.
// [R4] Scrambler state starts nonzero, giving a maximal-length sequence.
// [R5] Octets enter and leave the scrambler least significant bit first.
// [R6] Checks are the remainder of shifted message by generator, GF(256).
// [R7] Generator is product of (D plus alpha^i), i from zero to checks-1.
// [R8] Octet bits d7..d0 are field coefficients of alpha^7..alpha^0.
// [R9] Even check counts up to 16 and both mandatory code lengths work.
// [R10] Codeword length never exceeds 255 octets.
// [R11] Interleaver writes one block while an interleaved block is read.
// [R12] Octet j of a block is delayed by (depth-1) times j octets.
// [R13] Depth minus one is multiplier times block length.
// [R14] Depth is set by management; zero depth gives lowest latency.
// [R15] Without a fast buffer, zero depth carries non-interleaved data.
// [R16] A frame holds whole coded octets, fast before interleaved.
// [R17] One whole codeword per frame in the fast path is only advised.
// [R18] Packet length is ceiling of rate octets over 138 frames.
// [R19] Stuff dummies 0x3A fill the last slot of the first packets.
// [R20] Overhead octets head each packet; packet groups are then coded.
// [R21] Fill dummies 0xD3 trail the first packets of each group.
// [R22] Packet group size equals codeword length.
// [R23] Upstream presents octets on octet strobes from this block.
// [R24] Receive path descrambles and deinterleaves with complementary delays.
`timescale 1ns/100ps
module mctf_framer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // Configuration
    input  wire logic        cfg_enable,
    input  wire logic [19:0] cfg_rate_octets,
    input  wire logic [7:0]  cfg_packet_len,
    input  wire logic [7:0]  cfg_overhead_len,
    input  wire logic [7:0]  cfg_msg_len,
    input  wire logic [4:0]  cfg_check_len,
    input  wire logic [7:0]  cfg_fill_count,
    input  wire logic [7:0]  cfg_tri_mult,
    input  wire logic [7:0]  cfg_block_len,
    // Status
    output logic             cfg_error,
    output logic             running,
    // Transmit octets from upstream
    output logic             tx_octet_strobe,
    input  wire logic [7:0]  tx_octet,
    output logic             oh_octet_strobe,
    input  wire logic [7:0]  oh_octet,
    output logic             tx_frame_strobe,
    // Line side
    input  wire logic        line_bit_req,
    output logic             line_bit,
    // Receive octets
    input  wire logic        rx_octet_valid,
    input  wire logic [7:0]  rx_octet,
    output logic             rx_data_valid,
    output logic [7:0]       rx_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // Declarations
    mctf_pkg::mctf_state_t st_q;
    logic [4:0]  gi_q;
    logic [7:0]  apow_q;
    logic [7:0]  g_q [mctf_pkg::CHECK_SLOTS+1];
    logic [7:0]  p_q [mctf_pkg::CHECK_SLOTS];
    logic [22:0] scr_q;
    logic [22:0] dscr_q;
    logic [8:0]  slot_q;
    logic [7:0]  pkt_q;
    logic [7:0]  frame_q;
    logic [7:0]  msg_q;
    logic [7:0]  j_q;
    logic [7:0]  rj_q;
    logic [4:0]  chk_q;
    logic [2:0]  bit_q;
    logic [7:0]  shift_q;
    logic        req_s1_q;
    logic        req_s2_q;
    logic        req_s3_q;
    logic        rx_v1_q;
    logic [8:0]  n_len;
    logic [8:0]  pl_end;
    logic [19:0] stuff_cnt;
    logic        req_edge;
    logic        adv;
    logic        chk;
    logic        is_oh;
    logic        is_fill;
    logic        is_last_pay;
    logic        fill_here;
    logic        stuff_here;
    logic        pkt_last;
    logic [7:0]  raw;
    logic [30:0] scr_res;
    logic [7:0]  code;
    logic [7:0]  p_top;
    logic [7:0]  fb;
    logic [23:0] tx_dly;
    logic [23:0] rx_dly;
    logic [7:0]  tx_ring_out;
    logic [7:0]  rx_ring_out;
    logic [30:0] dscr_res;

    // ==========================================================
    // Configuration checks and derived counts
    assign n_len     = {1'b0, cfg_msg_len} + {4'h0, cfg_check_len}; // R22
    assign pl_end    = {1'b0, cfg_overhead_len} + {1'b0, cfg_packet_len};
    assign stuff_cnt = {12'h000, cfg_packet_len} * {12'h000, mctf_pkg::STUFF_PERIOD}
                       - cfg_rate_octets; // R18
    // Odd or oversized check counts and long codewords keep the block idle
    assign cfg_error = (n_len > mctf_pkg::MAX_CODEWORD) || cfg_check_len[0] // R10 R9
                       || (cfg_check_len > mctf_pkg::MAX_CHECK) || (cfg_msg_len == 8'h00)
                       || (cfg_block_len == 8'h00) || (pl_end == 9'h000);
    assign running   = (st_q == mctf_pkg::ST_RUN);

    // ==========================================================
    // Control: generator build, then run
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= mctf_pkg::ST_IDLE;
            gi_q <= '0;
        end else begin
            unique case (st_q)
                mctf_pkg::ST_IDLE: begin
                    gi_q <= '0;
                    if (cfg_enable && !cfg_error) begin
                        st_q <= (cfg_check_len == 5'h00) ? mctf_pkg::ST_RUN : mctf_pkg::ST_GEN;
                    end
                end
                mctf_pkg::ST_GEN: begin
                    gi_q <= gi_q + 5'h01;
                    if (gi_q == cfg_check_len - 5'h01) begin
                        st_q <= mctf_pkg::ST_RUN;
                    end
                end
                mctf_pkg::ST_RUN: begin
                    if (!cfg_enable) begin
                        st_q <= mctf_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Generator built one root per cycle, so any even check count costs no table
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            apow_q <= mctf_pkg::GF_ONE;
        end else if (st_q == mctf_pkg::ST_IDLE) begin
            apow_q <= mctf_pkg::GF_ONE;
        end else if (st_q == mctf_pkg::ST_GEN) begin
            apow_q <= mctf_pkg::gf_mul(apow_q, mctf_pkg::GF_ALPHA); // R7
        end
    end

    for (genvar k = 0; k <= mctf_pkg::CHECK_SLOTS; k++) begin : g_gen
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                g_q[k] <= (k == 0) ? mctf_pkg::GF_ONE : 8'h00;
            end else if (st_q == mctf_pkg::ST_IDLE) begin
                g_q[k] <= (k == 0) ? mctf_pkg::GF_ONE : 8'h00;
            end else if (st_q == mctf_pkg::ST_GEN) begin
                g_q[k] <= ((k == 0) ? 8'h00 : g_q[(k == 0) ? 0 : k-1])
                          ^ mctf_pkg::gf_mul(apow_q, g_q[k]); // R7
            end
        end
    end

    // ==========================================================
    // Line request sync and octet step
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= line_bit_req;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    assign req_edge = req_s2_q && !req_s3_q;
    assign adv      = running && req_edge && (bit_q == 3'h0);
    assign chk      = (chk_q != 5'h00);

    // ==========================================================
    // Packet assembly
    assign is_oh       = slot_q < {1'b0, cfg_overhead_len};
    assign is_fill     = slot_q == pl_end;
    assign is_last_pay = slot_q == pl_end - 9'h001;
    assign fill_here   = pkt_q < cfg_fill_count; // R21
    assign stuff_here  = {12'h000, frame_q} < stuff_cnt; // R19
    assign pkt_last    = fill_here ? is_fill : is_last_pay;

    always_comb begin
        if (is_oh) begin
            raw = oh_octet; // R20
        end else if (is_fill) begin
            raw = mctf_pkg::FILL_DUMMY; // R21
        end else if (is_last_pay && stuff_here) begin
            raw = mctf_pkg::STUFF_DUMMY; // R19
        end else begin
            raw = tx_octet;
        end
    end

    assign tx_octet_strobe = adv && !chk && !is_oh && !is_fill && !(is_last_pay && stuff_here); // R23
    assign oh_octet_strobe = adv && !chk && is_oh;
    assign tx_frame_strobe = adv && !chk && (slot_q == 9'h000);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            slot_q  <= '0;
            pkt_q   <= '0;
            frame_q <= '0;
        end else if (!running) begin
            slot_q  <= '0;
            pkt_q   <= '0;
            frame_q <= '0;
        end else if (adv && !chk) begin
            slot_q <= pkt_last ? 9'h000 : slot_q + 9'h001;
            if (pkt_last) begin
                pkt_q   <= ({1'b0, pkt_q} == n_len - 9'h001) ? 8'h00 : pkt_q + 8'h01; // R22
                frame_q <= (frame_q == mctf_pkg::STUFF_PERIOD - 8'h01) ? 8'h00 : frame_q + 8'h01; // R18
            end
        end
    end

    // ==========================================================
    // Scrambler: payload MSB becomes the first bit processed
    assign scr_res = mctf_pkg::scramble(mctf_pkg::bit_rev(raw), scr_q, 1'b0); // R2 R5 R3

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scr_q <= mctf_pkg::SCR_SEED; // R4
        end else if (!running) begin
            scr_q <= mctf_pkg::SCR_SEED; // R4
        end else if (adv && !chk) begin
            scr_q <= scr_res[30:8]; // R3
        end
    end

    // ==========================================================
    // Reed-Solomon encoder: division remainder in a parity shift register
    assign p_top = (cfg_check_len == 5'h00) ? 8'h00 : p_q[4'(cfg_check_len - 5'h01)];
    assign fb    = chk ? 8'h00 : (scr_res[7:0] ^ p_top); // R8
    assign code  = chk ? p_top : scr_res[7:0]; // R6

    for (genvar k = 0; k < mctf_pkg::CHECK_SLOTS; k++) begin : g_par
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                p_q[k] <= '0;
            end else if (!running) begin
                p_q[k] <= '0;
            end else if (adv) begin
                // With fb at zero this is a plain shift that drains the checks
                p_q[k] <= ((k == 0) ? 8'h00 : p_q[(k == 0) ? 0 : k-1])
                          ^ mctf_pkg::gf_mul(fb, g_q[k]); // R6
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            msg_q <= '0;
            chk_q <= '0;
        end else if (!running) begin
            msg_q <= '0;
            chk_q <= '0;
        end else if (adv) begin
            if (chk) begin
                chk_q <= chk_q - 5'h01;
            end else if (msg_q == cfg_msg_len - 8'h01) begin
                msg_q <= '0;
                chk_q <= cfg_check_len; // R6 R9
            end else begin
                msg_q <= msg_q + 8'h01;
            end
        end
    end

    // ==========================================================
    // Interleaver: lane j waits multiplier x block x j octets
    assign tx_dly = 24'(cfg_tri_mult) * 24'(cfg_block_len) * 24'(j_q); // R12 R13 R14

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            j_q <= '0;
        end else if (!running) begin
            j_q <= '0;
        end else if (adv) begin
            j_q <= (j_q == cfg_block_len - 8'h01) ? 8'h00 : j_q + 8'h01; // R11
        end
    end

    mctf_delay_ring u_tx_ring (
        .clk   (clk),
        .nrst  (nrst),
        .step  (adv),
        .din   (code),
        .delay (tx_dly[mctf_pkg::RING_AW-1:0]),
        .dout  (tx_ring_out)
    );

    // ==========================================================
    // Serialiser: one octet behind the interleaver, whole octets only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_q    <= '0;
            shift_q  <= '0;
            line_bit <= 1'b0;
        end else if (!running) begin
            bit_q    <= '0;
            shift_q  <= '0;
            line_bit <= 1'b0;
        end else if (req_edge) begin
            bit_q <= bit_q + 3'h1; // R16
            if (bit_q == 3'h0) begin
                line_bit <= tx_ring_out[7]; // R1
                shift_q  <= {tx_ring_out[6:0], 1'b0};
            end else begin
                line_bit <= shift_q[7]; // R1
                shift_q  <= {shift_q[6:0], 1'b0};
            end
        end
    end

    // ==========================================================
    // Receive path: deinterleave, then descramble
    assign rx_dly   = 24'(cfg_tri_mult) * 24'(cfg_block_len) * 24'(cfg_block_len - 8'h01 - rj_q); // R24
    assign dscr_res = mctf_pkg::scramble(rx_ring_out, dscr_q, 1'b1); // R24

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rj_q <= '0;
        end else if (!running) begin
            rj_q <= '0;
        end else if (rx_octet_valid) begin
            rj_q <= (rj_q == cfg_block_len - 8'h01) ? 8'h00 : rj_q + 8'h01;
        end
    end

    mctf_delay_ring u_rx_ring (
        .clk   (clk),
        .nrst  (nrst),
        .step  (rx_octet_valid),
        .din   (rx_octet),
        .delay (rx_dly[mctf_pkg::RING_AW-1:0]),
        .dout  (rx_ring_out)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_v1_q       <= 1'b0;
            rx_data_valid <= 1'b0;
            rx_data       <= '0;
            dscr_q        <= '0;
        end else begin
            rx_v1_q       <= rx_octet_valid;
            rx_data_valid <= rx_v1_q;
            if (rx_v1_q) begin
                rx_data <= mctf_pkg::bit_rev(dscr_res[7:0]); // R24
                dscr_q  <= dscr_res[30:8];
            end
        end
    end

    // ==========================================================
    // Checks
    a_stuff_value: assert property (adv && !chk && !is_oh && is_last_pay && stuff_here && !is_fill
                                    |-> raw == mctf_pkg::STUFF_DUMMY) // R19
        else $error("stuff slot did not carry the stuff dummy");
    a_fill_value: assert property (adv && !chk && is_fill && !is_oh |-> raw == mctf_pkg::FILL_DUMMY) // R21
        else $error("fill slot did not carry the fill dummy");
    a_check_entry: assert property (adv && !chk && msg_q == cfg_msg_len - 8'h01 && cfg_check_len != 5'h00
                                    |=> chk_q == $past(cfg_check_len)) // R6
        else $error("check phase did not start after the last message octet");
    a_codeword_len: assert property (running |-> n_len <= mctf_pkg::MAX_CODEWORD) // R10
        else $error("running with a codeword longer than allowed");
    a_msb_first: assert property (adv |=> line_bit == $past(tx_ring_out[7])) // R1
        else $error("octet did not start with its top bit");
    a_strobe_step: assert property (tx_octet_strobe |-> !oh_octet_strobe ##1 !tx_octet_strobe && !oh_octet_strobe) // R23
        else $error("octet strobes overlapped or repeated on one step");
    a_scr_feedback: assert property (adv && !chk |=> scr_q[0] == $past(scr_res[7])) // R3
        else $error("scrambler state did not take the last output bit");
    a_gen_done: assert property (st_q == mctf_pkg::ST_GEN && gi_q == cfg_check_len - 5'h01
                                 |=> st_q == mctf_pkg::ST_RUN) // R7
        else $error("generator build overran the check count");
    a_lane_wrap: assert property (adv && j_q == cfg_block_len - 8'h01 |=> j_q == 8'h00) // R11
        else $error("interleaver lane did not wrap at block end");
    a_rx_latency: assert property (rx_octet_valid |-> ##2 rx_data_valid) // R24
        else $error("receive octet not delivered two cycles later");

    c_stuff: cover property (tx_octet_strobe ##1 adv && is_last_pay && stuff_here);
    c_fill: cover property (adv && is_fill && !chk);
    c_checks: cover property (adv && chk ##[1:200] adv && !chk);
    c_rx: cover property (rx_data_valid);

endmodule

// *** bench/mctf_far_end.sv ***
// Far-end model: upstream octet source and modulator bit sink
`timescale 1ns/100ps
module mctf_far_end (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Bench control
    input  wire logic       go,
    // Upstream octets
    input  wire logic       tx_octet_strobe,
    output logic      [7:0] tx_octet,
    input  wire logic       oh_octet_strobe,
    output logic      [7:0] oh_octet,
    // Modulator side
    output logic            line_bit_req,
    input  wire logic       line_bit,
    output logic      [7:0] line_octet,
    output logic            line_octet_valid
);
    logic [7:0] pay_q, oh_q, sh_q;
    logic [2:0] ph_q, nb_q;
    logic       st_q;
    // Octets wait ready before each strobe, so upstream never stalls
    assign tx_octet = pay_q;
    assign oh_octet = ~oh_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {pay_q, oh_q} <= '0;
        end else begin
            if (tx_octet_strobe) pay_q <= pay_q + 8'h01;
            if (oh_octet_strobe) oh_q <= oh_q + 8'h01;
        end
    end
    // ==========================================================
    // Bit clock stands still between runs; a bit is read at the next request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {ph_q, nb_q, st_q, sh_q, line_bit_req, line_octet, line_octet_valid} <= '0;
        end else begin
            line_octet_valid <= 1'b0;
            if (go || ph_q != 3'h0) ph_q <= ph_q + 3'h1;
            line_bit_req <= ph_q[2];
            if (ph_q == 3'h4 && st_q) begin
                sh_q <= {sh_q[6:0], line_bit};
                nb_q <= nb_q + 3'h1;
                line_octet <= {sh_q[6:0], line_bit};
                line_octet_valid <= (nb_q == 3'h7);
            end
            if (ph_q == 3'h4) st_q <= 1'b1;
        end
    end
endmodule

// *** bench/mctf_framer_tb.sv ***
// Self-checking bench of the multicarrier transmit framer
`timescale 1ns/100ps
module mctf_framer_tb;
    logic        clk = 0, nrst = 0, en = 0, go = 0, rxv = 0;
    logic [19:0] rate = 0;
    logic [7:0]  ul = 0, el = 0, kl = 0, fl = 0, ml = 0, il = 0, rxd = 0, r0 = 0, r1 = 0;
    logic [4:0]  rl = 0;
    logic [22:0] ts, ds = 0;
    logic [39:0] e;
    logic [31:0] v;
    wire         err, run, tst, ost, fst, req, lb, rdv, lov;
    wire  [7:0]  txo, oho, rdo, lo;
    int          seed, cyc = 0, nm = 0, nf = 0, n_mismatch = 0, cmp_count = 0;
    logic [7:0]  tx_q[$];
    logic [39:0] rx_q[$];
    // Config table: K, R, I, E, U, expected error
    logic [37:0] tab[9] = '{{8'd128, 5'd16, 8'd1, 8'd1, 8'd2, 1'b0}, {8'd224, 5'd16, 8'd1, 8'd1, 8'd2, 1'b0},
        {8'd4, 5'd0, 8'd1, 8'd1, 8'd2, 1'b0}, {8'd240, 5'd16, 8'd1, 8'd1, 8'd2, 1'b1},
        {8'd4, 5'd3, 8'd1, 8'd1, 8'd2, 1'b1}, {8'd4, 5'd18, 8'd1, 8'd1, 8'd2, 1'b1},
        {8'd0, 5'd2, 8'd1, 8'd1, 8'd2, 1'b1}, {8'd4, 5'd2, 8'd0, 8'd1, 8'd2, 1'b1},
        {8'd4, 5'd2, 8'd1, 8'd0, 8'd0, 1'b1}};

    mctf_framer u_dut (.clk(clk), .nrst(nrst), .cfg_enable(en), .cfg_rate_octets(rate), .cfg_packet_len(ul),
        .cfg_overhead_len(el), .cfg_msg_len(kl), .cfg_check_len(rl), .cfg_fill_count(fl), .cfg_tri_mult(ml),
        .cfg_block_len(il), .cfg_error(err), .running(run), .tx_octet_strobe(tst), .tx_octet(txo),
        .oh_octet_strobe(ost), .oh_octet(oho), .tx_frame_strobe(fst), .line_bit_req(req), .line_bit(lb),
        .rx_octet_valid(rxv), .rx_octet(rxd), .rx_data_valid(rdv), .rx_data(rdo));
    mctf_far_end u_far (.clk(clk), .nrst(nrst), .go(go), .tx_octet_strobe(tst), .tx_octet(txo),
        .oh_octet_strobe(ost), .oh_octet(oho), .line_bit_req(req), .line_bit(lb), .line_octet(lo),
        .line_octet_valid(lov));

    function automatic logic [7:0] rev(input logic [7:0] a);
        return {<<{a}};
    endfunction
    function automatic logic [7:0] mul2(input logic [7:0] a);
        return {a[6:0], 1'b0} ^ (a[7] ? 8'h1d : 8'h00);
    endfunction
    // Self-synchronising form: feedback from output bits, or from input bits when undoing
    function automatic logic [7:0] scr(input logic [7:0] m, input logic d, inout logic [22:0] s);
        logic [7:0] y;
        for (int b = 0; b < 8; b++) begin
            y[b] = m[b] ^ s[17] ^ s[22];
            s = {s[21:0], d ? m[b] : y[b]};
        end
        return y;
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Two checks per codeword: generator (D+1)(D+alpha)
    task emit(input logic [7:0] a);
        logic [7:0] c, f;
        c = scr(rev(a), 1'b0, ts);
        tx_q.push_back(c);
        f = c ^ r0;
        r0 = r1 ^ mul2(f) ^ f;
        r1 = mul2(f);
        nm++;
        if (nm == 4) begin
            tx_q.push_back(r0);
            tx_q.push_back(r1);
            {nm, r0, r1} = '0;
        end
    endtask
    task wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fst === 1'b1) nf <= nf + 1;
        if (lov === 1'b1 && tx_q.size() > 0) chk(lo, tx_q.pop_front());
        if (rdv === 1'b1) begin
            e = rx_q.size() > 0 ? rx_q.pop_front() : '1;
            chk(cyc, e[39:8]);
            chk(rdo, e[7:0]);
        end
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        seed = 32'h32de3ba4;
        repeat (6) @(posedge clk);
        nrst <= 1;
        foreach (tab[t]) begin
            @(posedge clk);
            {kl, rl, il, el, ul} <= tab[t][37:1];
            @(posedge clk);
            chk(err, tab[t][0]);
        end
        $display("test config limits done");
        // One stuff per 138 frames, two fill dummies per group of six packets
        {kl, rl, il, el, ul, rate, fl, en} <= {8'd4, 5'd2, 8'd1, 8'd1, 8'd2, 20'd275, 8'd2, 1'b1};
        tx_q.push_back(8'h00);
        ts = mctf_pkg::SCR_SEED;
        v = 0;
        for (int p = 0; p < 12; p++) begin
            emit(~v[15:8]);
            emit(v[7:0]);
            v = v + 32'h101;
            if (p % 138 < 2 * 138 - 275) emit(8'h3a);
            else begin
                emit(v[7:0]);
                v = v + 32'h1;
            end
            if (p % 6 < 2) emit(8'hd3);
        end
        for (int w = 0; w < 50 && run !== 1'b1; w++) @(posedge clk);
        chk(run, 1);
        go <= 1;
        while (tx_q.size() > 0 && cyc < 15000) @(posedge clk);
        go <= 0;
        // A stalled line leaves notes behind; twelve packets plus the one already started
        chk(tx_q.size(), 0);
        chk(nf, 13);
        $display("test transmit frames done");
        repeat (60) begin
            @(posedge clk);
            v = $random(seed);
            rxv <= v[0] | v[1];
            rxd <= v[15:8];
            if (v[0] | v[1]) rx_q.push_back({cyc + 3, rev(scr(v[15:8], 1'b1, ds))});
        end
        @(posedge clk);
        rxv <= 0;
        repeat (6) @(posedge clk);
        chk(rx_q.size(), 0);
        $display("test receive path done");
        wrap_up();
    end
endmodule
